// File: design/pmc_params.svh
// offsets, field positions, reset values and timing counts of the power mode block
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH

`define PMC_MODE_ADDR 32'hE01FC0C0
`define PMC_GATE_ADDR 32'hE01FC0C4

`define PMC_MODE_IDLE_BIT 0
`define PMC_MODE_PD_BIT 1
`define PMC_MODE_BODOFF_BIT 2
`define PMC_MODE_RESET 8'h00
`define PMC_MODE_MASK 8'h07

`define PMC_GATE_TIMER0 1
`define PMC_GATE_TIMER1 2
`define PMC_GATE_SERIAL0 3
`define PMC_GATE_SERIAL1 4
`define PMC_GATE_PWM 5
`define PMC_GATE_TWOWIRE0 7
`define PMC_GATE_SERPERIPH0 8
`define PMC_GATE_CALENDAR 9
`define PMC_GATE_SYNCSERIAL 10
`define PMC_GATE_CONVERTER0 12
`define PMC_GATE_TWOWIRE1 19
`define PMC_GATE_CONVERTER1 20
`define PMC_GATE_MASK 32'h001817BE
`define PMC_GATE_RESET 32'h001817BE

`define PMC_CLK_PERIOD_PS 5000
`define PMC_RST_FILT_NS 300
`define PMC_RST_FILT_CYCLES ((`PMC_RST_FILT_NS * 1000 + `PMC_CLK_PERIOD_PS - 1) / `PMC_CLK_PERIOD_PS)

`endif

// File: design/pmc_pkg.sv
// types shared by the power mode block
`default_nettype none
package pmc_pkg;

    typedef enum logic [1:0] {
        PMC_RUN = 2'b00,
        PMC_IDLE = 2'b01,
        PMC_PDOWN = 2'b10,
        PMC_WAKE = 2'b11
    } pmc_state_e;

    typedef struct packed {
        logic [4:0] rsvd;
        logic brownout_off_in_sleep;
        logic powerdown_request;
        logic idle_request;
    } pmc_mode_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic aon_clk_en;
        logic osc_en;
        logic bod_en;
    } pmc_clk_ctl_s;

endpackage : pmc_pkg
`default_nettype wire

// File: design/pmc_power_mode.sv
// power mode, clock gating and reset sequencing with an apb register port
//
// How it works
// RULE1: idle bit stops only the processor clock; peripherals keep running.
// RULE2: in idle, an enabled interrupt or external wake restarts the processor clock.
// RULE3: power-down bit stops the oscillator and every on-chip clock.
// RULE4: external wake in power-down restarts oscillator, clears power-down bit, resumes.
// RULE5: power-down with detector kept on: brown-out trip ends power-down.
// RULE6: power-down plus detector-off bit switches the brown-out detector off.
// RULE7: without power-down the detector-off bit changes nothing.
// RULE8: software writes zeros to reserved bits; reads of them are undefined.
// RULE9: each gating bit enables one peripheral clock when one.
// RULE10: watchdog, gpio, pin mux and system control stay clocked always; the code clocks them in run and idle only.
// RULE11: software only touches a peripheral while its gating bit is one.
// RULE12: gating bit map for timers, serials, pwm, twowire, spi, calendar, converters.
// RULE13: every reset sets all defined gating bits to one.
// RULE14: software clears converter power before its gating bit, sets gating first.
// RULE15: power-conscious software leaves ones only for peripherals in use.
// RULE16: chip reset comes only from the filtered reset pin and the watchdog.
// RULE17: any chip reset starts the wakeup timer.
// RULE18: idle and power-down both set means power-down.
// RULE19: resuming from idle or power-down loses or repeats no instruction.
// RULE20: a gated-off peripheral reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"

module pmc_power_mode
    import pmc_pkg::*;
#(
    parameter int WAKE_CYCLES = 2048,
    parameter int FILT_CYCLES = `PMC_RST_FILT_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic IRQ_PENDING,
    input wire logic EXT_WAKE,
    input wire logic RESET_PIN_N,
    input wire logic WDT_RESET,
    input wire logic BOD_TRIP,
    input wire logic PBUS_VALID,
    input wire logic PBUS_WRITE,
    input wire logic [4:0] PBUS_SEL_IDX,
    input wire logic [31:0] PBUS_RDATA_IN,
    output logic PBUS_WR_EN,
    output logic [31:0] PBUS_RDATA,
    output logic CPU_CLK_EN,
    output logic AON_CLK_EN,
    output logic [31:0] PERIPH_CLK_EN,
    output logic OSC_EN,
    output logic BOD_EN,
    output logic CHIP_RESET_N,
    output logic WAKE_TIMER_START
);

    localparam logic [31:0] GATE_MASK = `PMC_GATE_MASK;

    if (WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin : g_bad_wake
        $error("WAKE_CYCLES out of range");
    end
    if (FILT_CYCLES < 1 || FILT_CYCLES > 255) begin : g_bad_filt
        $error("FILT_CYCLES out of range");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and reset glitch filter
    // ----------------------------------------------------------------
    logic [2:0] sync1_r, sync1_nxt;
    logic [2:0] sync2_r, sync2_nxt;
    logic rst_filt_r, rst_filt_nxt;
    logic [7:0] filt_cnt_r, filt_cnt_nxt;
    logic ext_wake_s, bod_trip_s, rst_pin_s;

    assign rst_pin_s = sync2_r[0];
    assign ext_wake_s = sync2_r[1];
    assign bod_trip_s = sync2_r[2];

    always_comb begin
        sync1_nxt = {BOD_TRIP, EXT_WAKE, RESET_PIN_N};
        sync2_nxt = sync1_r;
        rst_filt_nxt = rst_filt_r;
        filt_cnt_nxt = 8'h00;
        if (rst_pin_s != rst_filt_r) begin
            filt_cnt_nxt = filt_cnt_r + 8'h01;
            if (filt_cnt_r == 8'(FILT_CYCLES - 1)) begin
                rst_filt_nxt = rst_pin_s; // RULE16
                filt_cnt_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sync1_r <= 3'h1;
            sync2_r <= 3'h1;
            rst_filt_r <= 1'b1;
            filt_cnt_r <= 8'h00;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            rst_filt_r <= rst_filt_nxt;
            filt_cnt_r <= filt_cnt_nxt;
        end
    end

    logic chip_rst;
    assign chip_rst = !rst_filt_r || WDT_RESET; // RULE16

    // ----------------------------------------------------------------
    // mode registers, gating register and power state machine
    // ----------------------------------------------------------------
    pmc_state_e state_r, state_nxt;
    pmc_mode_s mode_r, mode_nxt;
    logic [31:0] gate_r, gate_nxt;
    logic [15:0] wake_cnt_r, wake_cnt_nxt;
    logic from_reset_r, from_reset_nxt;
    logic chip_rst_d_r;
    logic wr_mode, wr_gate;
    pmc_clk_ctl_s ctl_nxt;
    logic rst_out_nxt, wt_start_nxt;

    assign wr_mode = PSEL && PENABLE && PREADY && PWRITE && PADDR == `PMC_MODE_ADDR;
    assign wr_gate = PSEL && PENABLE && PREADY && PWRITE && PADDR == `PMC_GATE_ADDR;

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        gate_nxt = gate_r;
        wake_cnt_nxt = wake_cnt_r;
        from_reset_nxt = from_reset_r;
        if (wr_mode) begin
            mode_nxt = pmc_mode_s'(PWDATA[7:0] & `PMC_MODE_MASK);
        end
        if (wr_gate) begin
            gate_nxt = PWDATA & `PMC_GATE_MASK; // RULE9
        end
        case (state_r)
            PMC_RUN: begin
                if (mode_r.powerdown_request) begin
                    state_nxt = PMC_PDOWN; // RULE18
                end else if (mode_r.idle_request) begin
                    state_nxt = PMC_IDLE; // RULE1
                end
            end
            PMC_IDLE: begin
                if (IRQ_PENDING || ext_wake_s) begin
                    mode_nxt.idle_request = 1'b0; // RULE2
                    state_nxt = PMC_RUN;
                end
            end
            PMC_PDOWN: begin
                if (ext_wake_s || (bod_trip_s && !mode_r.brownout_off_in_sleep)) begin
                    mode_nxt.powerdown_request = 1'b0; // RULE4 RULE5
                    mode_nxt.idle_request = 1'b0;
                    wake_cnt_nxt = 16'h0000;
                    state_nxt = PMC_WAKE;
                end
            end
            PMC_WAKE: begin
                wake_cnt_nxt = wake_cnt_r + 16'h0001;
                if (wake_cnt_r == 16'(WAKE_CYCLES - 1)) begin
                    from_reset_nxt = 1'b0;
                    state_nxt = PMC_RUN; // RULE19
                end
            end
            default: state_nxt = PMC_RUN;
        endcase
        if (chip_rst) begin
            mode_nxt = pmc_mode_s'(`PMC_MODE_RESET);
            gate_nxt = `PMC_GATE_RESET; // RULE13
            wake_cnt_nxt = 16'h0000;
            from_reset_nxt = 1'b1;
            state_nxt = PMC_WAKE; // RULE17
        end
        ctl_nxt.cpu_clk_en = state_nxt == PMC_RUN; // RULE1 RULE19
        ctl_nxt.aon_clk_en = state_nxt == PMC_RUN || state_nxt == PMC_IDLE; // RULE10
        ctl_nxt.osc_en = state_nxt != PMC_PDOWN; // RULE3
        ctl_nxt.bod_en = !(state_nxt == PMC_PDOWN && mode_nxt.brownout_off_in_sleep); // RULE6 RULE7
        rst_out_nxt = !(chip_rst || (state_nxt == PMC_WAKE && from_reset_nxt));
        wt_start_nxt = (chip_rst && !chip_rst_d_r) || (state_r == PMC_PDOWN && state_nxt == PMC_WAKE); // RULE17
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            state_r <= PMC_WAKE;
            mode_r <= pmc_mode_s'(`PMC_MODE_RESET);
            gate_r <= `PMC_GATE_RESET; // RULE13
            wake_cnt_r <= 16'h0000;
            from_reset_r <= 1'b1;
            chip_rst_d_r <= 1'b0;
            CPU_CLK_EN <= 1'b0;
            AON_CLK_EN <= 1'b0;
            PERIPH_CLK_EN <= 32'h00000000;
            OSC_EN <= 1'b1;
            BOD_EN <= 1'b1;
            CHIP_RESET_N <= 1'b0;
            WAKE_TIMER_START <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            gate_r <= gate_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            from_reset_r <= from_reset_nxt;
            chip_rst_d_r <= chip_rst;
            CPU_CLK_EN <= ctl_nxt.cpu_clk_en;
            AON_CLK_EN <= ctl_nxt.aon_clk_en;
            PERIPH_CLK_EN <= ctl_nxt.aon_clk_en ? gate_nxt : 32'h00000000; // RULE9 RULE12
            OSC_EN <= ctl_nxt.osc_en;
            BOD_EN <= ctl_nxt.bod_en;
            CHIP_RESET_N <= rst_out_nxt;
            WAKE_TIMER_START <= wt_start_nxt;
        end
    end

    // ----------------------------------------------------------------
    // apb slave and gated peripheral access
    // ----------------------------------------------------------------
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;
    logic pbus_ok;

    assign pbus_ok = !GATE_MASK[PBUS_SEL_IDX] || gate_r[PBUS_SEL_IDX];

    always_comb begin
        prdata_nxt = PRDATA;
        pslverr_nxt = PSLVERR;
        if (PSEL && !PENABLE) begin
            prdata_nxt = 32'h00000000;
            pslverr_nxt = 1'b0;
            if (PADDR == `PMC_MODE_ADDR) begin
                prdata_nxt = {24'h000000, mode_r};
            end else if (PADDR == `PMC_GATE_ADDR) begin
                prdata_nxt = gate_r;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
            PBUS_WR_EN <= 1'b0;
            PBUS_RDATA <= 32'h00000000;
        end else begin
            PRDATA <= prdata_nxt;
            PSLVERR <= pslverr_nxt;
            PREADY <= 1'b1;
            PBUS_WR_EN <= PBUS_VALID && PBUS_WRITE && pbus_ok; // RULE20
            PBUS_RDATA <= (PBUS_VALID && pbus_ok) ? PBUS_RDATA_IN : 32'h00000000; // RULE20
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_idle_cpu_off: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE1
        state_r == PMC_IDLE |-> !CPU_CLK_EN && AON_CLK_EN && OSC_EN)
        else $error("idle must stop only the processor clock");

    a_idle_periph: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE1 RULE10
        state_r == PMC_IDLE |-> PERIPH_CLK_EN == gate_r)
        else $error("idle stopped a peripheral clock");

    a_aon_run: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE10
        state_r == PMC_RUN |-> AON_CLK_EN && OSC_EN)
        else $error("always-on clock stopped while running");

    a_idle_wake: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE2
        state_r == PMC_IDLE && IRQ_PENDING && !chip_rst |=> CPU_CLK_EN && !mode_r.idle_request)
        else $error("interrupt did not restart processor clock");

    a_pd_all_off: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE3
        state_r == PMC_PDOWN |-> !OSC_EN && !CPU_CLK_EN && !AON_CLK_EN && PERIPH_CLK_EN == 32'h00000000)
        else $error("power-down left a clock running");

    a_pd_wake_seq: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE4
        state_r == PMC_PDOWN && ext_wake_s && !chip_rst
        |=> OSC_EN && WAKE_TIMER_START && !mode_r.powerdown_request && state_r == PMC_WAKE)
        else $error("external wake did not restart the oscillator");

    a_wake_ends: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE4 RULE19
        state_r == PMC_WAKE && wake_cnt_r == 16'(WAKE_CYCLES - 1) && !chip_rst |=> CPU_CLK_EN && CHIP_RESET_N)
        else $error("wakeup did not resume the processor");

    a_wake_bound: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE17
        state_r == PMC_WAKE |-> wake_cnt_r < 16'(WAKE_CYCLES))
        else $error("wakeup count ran past its end");

    a_bod_kept: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE5
        state_r == PMC_PDOWN && !mode_r.brownout_off_in_sleep |-> BOD_EN)
        else $error("brown-out detector off while kept on");

    a_bod_off_pd: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE6
        state_r == PMC_PDOWN && mode_r.brownout_off_in_sleep |-> !BOD_EN)
        else $error("brown-out detector not switched off");

    a_bod_no_pd: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE7
        state_r != PMC_PDOWN |-> BOD_EN)
        else $error("detector-off bit acted outside power-down");

    a_rsvd_zero: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE8 RULE12
        mode_r.rsvd == 5'h00 && (gate_r & ~GATE_MASK) == 32'h00000000)
        else $error("reserved register bit was stored");

    a_gate_follow: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE9 RULE12
        state_r == PMC_RUN |-> PERIPH_CLK_EN == $past(gate_nxt) && (PERIPH_CLK_EN & ~GATE_MASK) == 32'h00000000)
        else $error("peripheral clock does not follow gating bit");

    a_reset_gates: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE13 RULE16
        chip_rst |=> gate_r == `PMC_GATE_RESET && !CHIP_RESET_N && state_r == PMC_WAKE)
        else $error("reset did not restore gating bits");

    a_wdt_reset: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE16
        WDT_RESET |=> !CHIP_RESET_N)
        else $error("watchdog did not reset the chip");

    a_reset_timer: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE17
        $rose(chip_rst) |=> WAKE_TIMER_START)
        else $error("chip reset did not start wakeup timer");

    a_pd_priority: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE18
        state_r == PMC_RUN && mode_r.idle_request && mode_r.powerdown_request && !chip_rst
        |=> state_r == PMC_PDOWN)
        else $error("idle taken instead of power-down");

    a_gated_access: assert property (@(posedge CORE_CLK) disable iff (!NRST) // RULE20
        PBUS_VALID && !pbus_ok |=> !PBUS_WR_EN && PBUS_RDATA == 32'h00000000)
        else $error("gated peripheral was accessed");

endmodule : pmc_power_mode
`default_nettype wire

// File: testbench/pmc_periph_model.sv
// peripheral side model: answers reads of the addressed peripheral
`timescale 1ns/1ps
`default_nettype none
module pmc_periph_model (
    input wire logic CORE_CLK,
    input wire logic PBUS_VALID,
    input wire logic [4:0] PBUS_SEL_IDX,
    output logic [31:0] PBUS_RDATA_IN
);
    // ------------------------------------------------------------
    // read data, scrambled while no access is in progress
    // ------------------------------------------------------------
    logic [31:0] last_r = 32'h00000000;
    always_comb begin
        PBUS_RDATA_IN = PBUS_VALID ? (32'h5A5A0000 | {27'h0, PBUS_SEL_IDX}) : ~last_r;
    end
    always_ff @(posedge CORE_CLK) begin
        last_r <= PBUS_RDATA_IN;
    end
endmodule : pmc_periph_model
`default_nettype wire

// File: testbench/power_mode_and_clock_gating_bench.sv
// self-checking bench of the power mode and clock gating block
`timescale 1ns/1ps
`default_nettype none
`include "pmc_params.svh"
module power_mode_and_clock_gating_bench;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    localparam int WAKE = 4;
    localparam int FILT = 4;
    logic core_clk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic irq_pending = 1'h0, ext_wake = 1'h0, reset_pin_n = 1'h1, wdt_reset = 1'h0, bod_trip = 1'h0;
    logic pbus_valid = 1'h0, pbus_write = 1'h0, pready, pslverr, pbus_wr_en, cpu_clk_en, aon_clk_en;
    logic osc_en, bod_en, chip_reset_n, wake_timer_start;
    logic [4:0] pbus_sel_idx = 5'h00;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, pbus_rdata, pbus_rdata_in, periph_clk_en, rd;
    logic [31:0] gw [5] = '{32'hFFFFFFFF, 32'h00000000, 32'h00100002, 32'h0007E841, 32'h00081000};
    logic [31:0] ge [5] = '{32'h001817BE, 32'h00000000, 32'h00100002, 32'h00000000, 32'h00081000};
    logic [7:0] pdm [4] = '{8'h02, 8'h06, 8'h03, 8'h07};
    int idx [12] = '{1, 2, 3, 4, 5, 7, 8, 9, 10, 12, 19, 20};
    int err_count = 0, n_tests = 0, cycles = 0, pulses = 0, p0, i, j, k;

    pmc_power_mode #(.WAKE_CYCLES(WAKE), .FILT_CYCLES(FILT)) u_pmc_power_mode (
        .CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ_PENDING(irq_pending),
        .EXT_WAKE(ext_wake), .RESET_PIN_N(reset_pin_n), .WDT_RESET(wdt_reset), .BOD_TRIP(bod_trip),
        .PBUS_VALID(pbus_valid), .PBUS_WRITE(pbus_write), .PBUS_SEL_IDX(pbus_sel_idx),
        .PBUS_RDATA_IN(pbus_rdata_in), .PBUS_WR_EN(pbus_wr_en), .PBUS_RDATA(pbus_rdata),
        .CPU_CLK_EN(cpu_clk_en), .AON_CLK_EN(aon_clk_en), .PERIPH_CLK_EN(periph_clk_en), .OSC_EN(osc_en),
        .BOD_EN(bod_en), .CHIP_RESET_N(chip_reset_n), .WAKE_TIMER_START(wake_timer_start));
    pmc_periph_model u_pmc_periph_model (.CORE_CLK(core_clk), .PBUS_VALID(pbus_valid),
        .PBUS_SEL_IDX(pbus_sel_idx), .PBUS_RDATA_IN(pbus_rdata_in));

    // ------------------------------------------------------------
    // clock, timeout, pulse counter and tasks
    // ------------------------------------------------------------
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (wake_timer_start === 1'h1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            err_count = err_count + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic wait_for(input int s, input logic v);
        for (int n = 0; n < 3000 && (s == 0 ? cpu_clk_en : s == 1 ? osc_en : chip_reset_n) !== v; n++) begin
            @(posedge core_clk);
        end
    endtask : wait_for
    task automatic pacc(input int id, input logic wr);
        @(posedge core_clk);
        pbus_valid <= 1'h1;
        pbus_sel_idx <= id[4:0];
        pbus_write <= wr;
        @(posedge core_clk);
        pbus_valid <= 1'h0;
        @(posedge core_clk);
    endtask : pacc

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        check({25'h0, cpu_clk_en, aon_clk_en, osc_en, bod_en, chip_reset_n, pready, 1'h0}, 32'h18);
        check(periph_clk_en, 32'h0);
        nrst <= 1'h1;
        @(posedge core_clk);
        check({31'h0, chip_reset_n}, 32'h0);
        wait_for(2, 1'h1);
        check({30'h0, chip_reset_n, aon_clk_en}, 32'h3);
        apb(1'h0, `PMC_MODE_ADDR, 32'h0);
        check(rd, 32'h00000000);
        for (i = 0; i < 5; i++) begin
            apb(1'h1, `PMC_GATE_ADDR, gw[i]);
            apb(1'h0, `PMC_GATE_ADDR, 32'h0);
            check(rd, i == 0 ? 32'h001817BE : ge[i]);
            check(periph_clk_en, i == 0 ? 32'h001817BE : ge[i]);
            for (j = 0; j < 12; j++) begin
                pacc(idx[j], 1'h1);
                check({31'h0, pbus_wr_en}, {31'h0, ge[i][idx[j]]});
                pacc(idx[j], 1'h0);
                check(pbus_rdata, ge[i][idx[j]] ? 32'h5A5A0000 | idx[j] : 32'h0);
            end
        end
        apb(1'h0, 32'hE01FC0C8, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        for (k = 0; k < 2; k++) begin
            apb(1'h1, `PMC_MODE_ADDR, 32'h01);
            repeat (3) @(posedge core_clk);
            check({29'h0, cpu_clk_en, aon_clk_en, osc_en}, 32'h3);
            check(periph_clk_en, ge[4]);
            irq_pending <= (k == 0);
            ext_wake <= (k == 1);
            wait_for(0, 1'h1);
            check({31'h0, cpu_clk_en}, 32'h1);
            irq_pending <= 1'h0;
            ext_wake <= 1'h0;
            repeat (4) @(posedge core_clk);
            apb(1'h0, `PMC_MODE_ADDR, 32'h0);
            check(rd, 32'h0);
        end
        for (k = 0; k < 4; k++) begin
            apb(1'h1, `PMC_MODE_ADDR, {24'h0, pdm[k]});
            repeat (3) @(posedge core_clk);
            check({28'h0, cpu_clk_en, aon_clk_en, osc_en, bod_en}, {31'h0, ~pdm[k][2]});
            check(periph_clk_en, 32'h0);
            p0 = pulses;
            bod_trip <= 1'h1;
            repeat (8) @(posedge core_clk);
            check({31'h0, osc_en}, {31'h0, ~pdm[k][2]});
            ext_wake <= 1'h1;
            wait_for(0, 1'h1);
            check(pulses - p0, 32'h1);
            bod_trip <= 1'h0;
            ext_wake <= 1'h0;
            repeat (4) @(posedge core_clk);
            apb(1'h0, `PMC_MODE_ADDR, 32'h0);
            check({30'h0, rd[2:1]}, {30'h0, pdm[k][2], 1'h0});
        end
        apb(1'h1, `PMC_MODE_ADDR, 32'h04);
        p0 = pulses;
        bod_trip <= 1'h1;
        repeat (8) @(posedge core_clk);
        check({28'h0, cpu_clk_en, osc_en, bod_en, chip_reset_n}, 32'hF);
        check(pulses - p0, 32'h0);
        bod_trip <= 1'h0;
        reset_pin_n <= 1'h0;
        @(posedge core_clk);
        reset_pin_n <= 1'h1;
        repeat (10) @(posedge core_clk);
        check({31'h0, chip_reset_n}, 32'h1);
        for (k = 0; k < 2; k++) begin
            apb(1'h1, `PMC_GATE_ADDR, 32'h0);
            p0 = pulses;
            reset_pin_n <= (k == 0) ? 1'h0 : 1'h1;
            wdt_reset <= (k == 1);
            wait_for(2, 1'h0);
            check({31'h0, chip_reset_n}, 32'h0);
            reset_pin_n <= 1'h1;
            wdt_reset <= 1'h0;
            wait_for(2, 1'h1);
            check(pulses - p0, 32'h1);
            apb(1'h0, `PMC_GATE_ADDR, 32'h0);
            check(rd, 32'h001817BE);
            apb(1'h0, `PMC_MODE_ADDR, 32'h0);
            check(rd, 32'h0);
        end
        apb(1'h1, `PMC_GATE_ADDR, 32'h0);
        nrst <= 1'h0;
        repeat (3) @(posedge core_clk);
        check({31'h0, chip_reset_n}, 32'h0);
        check(periph_clk_en, 32'h0);
        nrst <= 1'h1;
        @(posedge core_clk);
        check({30'h0, cpu_clk_en, pready}, 32'h0);
        wait_for(2, 1'h1);
        apb(1'h0, `PMC_GATE_ADDR, 32'h0);
        check(rd, 32'h001817BE);
        print_verdict();
    end
endmodule : power_mode_and_clock_gating_bench
`default_nettype wire
